//--- core/sky_cmd_pkg.sv
package sky_cmd_pkg;

	// ASCII characters used by the command parser and the line composer.
	localparam logic [7:0] CH_CR     = 8'h0D;
	localparam logic [7:0] CH_LF     = 8'h0A;
	localparam logic [7:0] CH_SPACE  = 8'h20;
	localparam logic [7:0] CH_COMMA  = 8'h2C;
	localparam logic [7:0] CH_MINUS  = 8'h2D;
	localparam logic [7:0] CH_DOT    = 8'h2E;
	localparam logic [7:0] CH_ZERO   = 8'h30;
	localparam logic [7:0] CH_NINE   = 8'h39;
	localparam logic [7:0] CH_UP_C   = 8'h43;
	localparam logic [7:0] CH_UP_H   = 8'h48;
	localparam logic [7:0] CH_UP_I   = 8'h49;
	localparam logic [7:0] CH_UP_P   = 8'h50;
	localparam logic [7:0] CH_UP_S   = 8'h53;
	localparam logic [7:0] CH_UP_T   = 8'h54;
	localparam logic [7:0] CH_LO_C   = 8'h63;
	localparam logic [7:0] CH_LO_F   = 8'h66;
	localparam logic [7:0] CH_LO_M   = 8'h6D;
	localparam logic [7:0] CH_LO_P   = 8'h70;
	localparam logic [7:0] CH_LO_R   = 8'h72;
	localparam logic [7:0] CH_LO_S   = 8'h73;
	localparam logic [7:0] CH_LO_T   = 8'h74;
	localparam logic [7:0] CH_X      = 8'h78;
	localparam logic [7:0] CH_LO_Z   = 8'h7A;

	// Lengths of the three response lines, line ends included.
	localparam logic [6:0] LEN_STAT  = 7'h35;
	localparam logic [6:0] LEN_SREAD = 7'h27;
	localparam logic [6:0] LEN_SSET  = 7'h5F;

	// Outgoing connection port of the network adapter.
	localparam logic [15:0] LISTENER_PORT = 16'h2712;

	// Temperature conversion: tenths of a degree = raw * 3300 / 1024 - 500.
	localparam logic [47:0] TEMP_MUL   = 48'hCE4;
	localparam int          TEMP_SHIFT = 10;
	localparam logic [47:0] TEMP_OFS   = 48'h1F4;
	localparam logic [47:0] TEMP_CLIP  = 48'h270F;

	// Period in milliseconds = counts * 1000 / 460800.
	localparam logic [47:0] MS_PER_S      = 48'h3E8;
	localparam logic [47:0] COUNT_RATE_HZ = 48'h70800;

	// Timing: one second at a 5 ns clock.
	localparam int SEC_NS        = 1000000000;
	localparam int CLK_PERIOD_NS = 5;
	localparam int CYCLES_PER_S  = SEC_NS / CLK_PERIOD_NS;

	// Reset values of the stored settings.
	localparam logic [39:0] RST_PERIOD = 40'h0;
	localparam logic [39:0] RST_THRESH = 40'h0;

	// Parser states, one-hot.
	typedef enum logic [2:0] {PS_IDLE = 3'h1, PS_NUM = 3'h2, PS_SIM = 3'h4} parse_e;

	// Response line being sent, one-hot.
	typedef enum logic [3:0] {LN_NONE = 4'h1, LN_STAT = 4'h2, LN_SREAD = 4'h4,
		LN_SSET = 4'h8} line_e;

	// Simulation inputs, ten BCD digits each.
	typedef struct packed {
		logic [39:0] counts;
		logic [39:0] freq;
		logic [39:0] temp;
	} sim_vals_s;

	// Write request towards the nonvolatile store.
	typedef struct packed {
		logic        valid;
		logic        is_thresh;
		logic [39:0] value;
	} nv_write_s;

	// Complete state of the interpreter core.
	typedef struct packed {
		parse_e      parse;
		logic [7:0]  cmd;
		logic [39:0] acc;
		logic [1:0]  fld;
		sim_vals_s   sim;
		logic [39:0] nv_period;
		logic [39:0] ram_period;
		logic [39:0] nv_thresh;
		logic [39:0] ram_thresh;
		line_e       line;
		logic [6:0]  idx;
		logic        tx_valid;
		logic [7:0]  tx_data;
		logic [31:0] sec_cnt;
		logic [33:0] secs;
		logic        report_req;
		nv_write_s   nv_wr;
	} core_state_s;

	// Ten BCD digits to binary.
	function automatic logic [33:0] bcd2bin(input logic [39:0] v);
		logic [33:0] a;
		a = '0;
		for (int d = 9; d >= 0; d--)
			a = 34'(a * 34'hA + 34'(v[4*d +: 4]));
		return a;
	endfunction

	// Binary to ten BCD digits by shift and add three.
	function automatic logic [39:0] bin2bcd(input logic [33:0] b);
		logic [39:0] r;
		r = '0;
		for (int i = 33; i >= 0; i--)
		begin
			for (int d = 0; d < 10; d++)
				if (r[4*d +: 4] > 4'h4)
					r[4*d +: 4] = r[4*d +: 4] + 4'h3;
			r = {r[38:0], b[i]};
		end
		return r;
	endfunction

endpackage

//--- core/sim_conv.sv
`timescale 1ns/1ps
`default_nettype none

// Turns the simulated counts and raw temperature into printable BCD values.
module sim_conv
(
	input  wire logic [39:0] counts_bcd_in,  // Simulated counts, BCD.
	input  wire logic [39:0] temp_bcd_in,    // Simulated temperature ADC value, BCD.
	output logic      [39:0] period_ms_out,  // Period in milliseconds, BCD.
	output logic             temp_neg_out,   // High when the temperature is below zero.
	output logic      [15:0] temp_deg_out    // Temperature in tenths of a degree, BCD.
);

	logic [47:0] raw;   // Raw temperature in binary.
	logic [47:0] scal;  // Raw value scaled to tenths plus offset.
	logic [47:0] mag;   // Magnitude of the temperature in tenths.
	logic [47:0] ms;    // Period in milliseconds.
	logic [39:0] tbcd;  // Temperature magnitude as BCD.

	// The formula is evaluated in tenths so a single decimal survives; the
	// magnitude is clipped to four digits because the line has room for no more.
	always_comb
	begin
		raw  = 48'(sky_cmd_pkg::bcd2bin(temp_bcd_in));
		scal = 48'((raw * sky_cmd_pkg::TEMP_MUL) >> sky_cmd_pkg::TEMP_SHIFT);
		temp_neg_out = (scal < sky_cmd_pkg::TEMP_OFS);
		if (temp_neg_out)
			mag = sky_cmd_pkg::TEMP_OFS - scal;
		else
			mag = scal - sky_cmd_pkg::TEMP_OFS;
		if (mag > sky_cmd_pkg::TEMP_CLIP)
			mag = sky_cmd_pkg::TEMP_CLIP;
		tbcd = sky_cmd_pkg::bin2bcd(mag[33:0]);
		temp_deg_out = tbcd[15:0];
		ms = (48'(sky_cmd_pkg::bcd2bin(counts_bcd_in)) * sky_cmd_pkg::MS_PER_S)
			/ sky_cmd_pkg::COUNT_RATE_HZ;
		period_ms_out = sky_cmd_pkg::bin2bcd(ms[33:0]);
	end

endmodule

`default_nettype wire

//--- core/sky_cmd_core.sv
// Function
// - P command writes period to nonvolatile and working.
// - p command writes working period only.
// - Period counts whole seconds between reports.
// - T command writes threshold to nonvolatile and working.
// - t command writes working threshold only.
// - Report only readings darker than the threshold.
// - Status line after query and every setting.
// - Status line: I, nonvolatile, working period.
// - Status line: nonvolatile, working threshold, suffix m.
// - Every line ends with CR then LF.
// - s command returns counts, frequency, temperature.
// - Temperature equals raw*3.3/1024 minus 0.5, over 0.01.
// - Separators are anything but x; x terminates.
// - S echoes values, then r and brightness.
// - S reports frequency, counts, period, temperature used.
// - Adapter connects to listener port on any output.
// - Interval report is reading plus serial number.
`timescale 1ns/1ps
`default_nettype none

module sky_cmd_core
#(
	parameter int          CYCLES_PER_S = sky_cmd_pkg::CYCLES_PER_S, // Clock cycles per second.
	parameter logic [31:0] SERIAL_BCD   = 32'h12345678               // Arbitrary serial value.
)
(
	input  wire logic                   clk_in,            // System clock, 200 MHz.
	input  wire logic                   reset_in,          // Synchronous reset, active high.
	input  wire logic                   rx_valid_in,       // A command byte is offered.
	input  wire logic [7:0]             rx_data_in,        // Command byte.
	output logic                        rx_ready_out,      // The byte is taken this cycle.
	output logic                        tx_valid_out,      // A response byte is offered.
	output logic [7:0]                  tx_data_out,       // Response byte.
	input  wire logic                   tx_ready_in,       // The link takes the byte.
	input  wire logic                   sim_mag_neg_in,    // Sign of the simulated brightness.
	input  wire logic [15:0]            sim_mag_in,        // Simulated brightness, BCD xx.xx.
	input  wire logic                   reading_neg_in,    // Sign of the live reading.
	input  wire logic [15:0]            reading_in,        // Live reading, BCD xx.xx.
	output sky_cmd_pkg::sim_vals_s      sim_out,           // Stored simulation values.
	output sky_cmd_pkg::nv_write_s      nv_wr_out,         // Nonvolatile write request.
	output logic                        report_req_out,    // Start one interval report.
	output logic [31:0]                 serial_out,        // Serial number for the report.
	output logic                        connect_req_out,   // Adapter opens a connection.
	output logic [15:0]                 listener_port_out  // Port the adapter connects to.
);

	sky_cmd_pkg::core_state_s st_r;    // Registered state.
	sky_cmd_pkg::core_state_s st_nxt;  // Next state.

	logic [39:0] period_ms;  // Period from counts, BCD milliseconds.
	logic        temp_neg;   // Temperature sign.
	logic [15:0] temp_deg;   // Temperature in tenths, BCD.
	logic        rx_hs;      // A byte is accepted.
	logic        tx_hs;      // A byte is delivered.
	logic        is_digit;   // The accepted byte is a decimal digit.
	logic        exec_cmd;   // A terminator arrives for an open command.
	logic        above;      // The live reading is above the working threshold.
	logic [6:0]  cur_len;    // Length of the line being sent.

	// Conversion of the stored simulation values for the simulation response.
	sim_conv u_conv
	(
		.counts_bcd_in (st_r.sim.counts),
		.temp_bcd_in   (st_r.sim.temp),
		.period_ms_out (period_ms),
		.temp_neg_out  (temp_neg),
		.temp_deg_out  (temp_deg)
	);

	// ASCII form of digit k, counted from the most significant of ten.
	function automatic logic [7:0] dig(input logic [39:0] v, input int k);
		return sky_cmd_pkg::CH_ZERO | {4'h0, v[4*(9-k) +: 4]};
	endfunction

	// Length of a response line.
	function automatic logic [6:0] line_len(input sky_cmd_pkg::line_e ln);
		case (ln)
			sky_cmd_pkg::LN_STAT:  return sky_cmd_pkg::LEN_STAT;
			sky_cmd_pkg::LN_SREAD: return sky_cmd_pkg::LEN_SREAD;
			sky_cmd_pkg::LN_SSET:  return sky_cmd_pkg::LEN_SSET;
			default:               return 7'h1;
		endcase
	endfunction

	// Character at column i of the given line, built from the stored values.
	function automatic logic [7:0] line_char(input sky_cmd_pkg::line_e ln,
		input logic [6:0] i, input sky_cmd_pkg::core_state_s s,
		input logic [39:0] pms, input logic tneg, input logic [15:0] tdeg,
		input logic mneg, input logic [15:0] mag);
		int n;
		logic [7:0] c;
		n = int'(i);
		c = sky_cmd_pkg::CH_SPACE;
		if (ln == sky_cmd_pkg::LN_STAT)
		begin
			// Interval status: periods end in s and thresholds in m.
			if (n == 0) c = sky_cmd_pkg::CH_UP_I;
			else if (n inside {1, 13, 25, 38}) c = sky_cmd_pkg::CH_COMMA;
			else if (n inside {[2:11]}) c = dig(s.nv_period, n - 2);
			else if (n == 12 || n == 24) c = sky_cmd_pkg::CH_LO_S;
			else if (n inside {[14:23]}) c = dig(s.ram_period, n - 14);
			else if (n inside {[26:33]}) c = dig(s.nv_thresh, n - 26);
			else if (n == 34 || n == 47) c = sky_cmd_pkg::CH_DOT;
			else if (n inside {[35:36]}) c = dig(s.nv_thresh, n - 27);
			else if (n == 37 || n == 50) c = sky_cmd_pkg::CH_LO_M;
			else if (n inside {[39:46]}) c = dig(s.ram_thresh, n - 39);
			else if (n inside {[48:49]}) c = dig(s.ram_thresh, n - 40);
			else if (n == 51) c = sky_cmd_pkg::CH_CR;
			else if (n == 52) c = sky_cmd_pkg::CH_LF;
		end
		else
		begin
			// Both simulation lines open with the three stored values.
			if (n == 0)
				c = (ln == sky_cmd_pkg::LN_SSET) ? sky_cmd_pkg::CH_UP_S : sky_cmd_pkg::CH_LO_S;
			else if (n inside {1, 13, 25}) c = sky_cmd_pkg::CH_COMMA;
			else if (n inside {[2:11]}) c = dig(s.sim.counts, n - 2);
			else if (n == 12) c = sky_cmd_pkg::CH_LO_C;
			else if (n inside {[14:23]}) c = dig(s.sim.freq, n - 14);
			else if (n == 24) c = sky_cmd_pkg::CH_LO_F;
			else if (n inside {[26:35]}) c = dig(s.sim.temp, n - 26);
			else if (n == 36) c = sky_cmd_pkg::CH_LO_T;
			else if (ln == sky_cmd_pkg::LN_SREAD)
			begin
				// The read line ends right after the temperature.
				if (n == 37) c = sky_cmd_pkg::CH_CR;
				else if (n == 38) c = sky_cmd_pkg::CH_LF;
			end
			else
			begin
				// The set line goes on with the calculated reading.
				if (n inside {37, 39, 47, 60, 72, 85}) c = sky_cmd_pkg::CH_COMMA;
				else if (n == 38) c = sky_cmd_pkg::CH_LO_R;
				else if (n == 40) c = mneg ? sky_cmd_pkg::CH_MINUS : sky_cmd_pkg::CH_SPACE;
				else if (n inside {[41:42]}) c = dig({24'h0, mag}, n - 35);
				else if (n == 43 || n == 80 || n == 90) c = sky_cmd_pkg::CH_DOT;
				else if (n inside {[44:45]}) c = dig({24'h0, mag}, n - 36);
				else if (n == 46) c = sky_cmd_pkg::CH_LO_M;
				else if (n inside {[48:57]}) c = dig(s.sim.freq, n - 48);
				else if (n == 58) c = sky_cmd_pkg::CH_UP_H;
				else if (n == 59) c = sky_cmd_pkg::CH_LO_Z;
				else if (n inside {[61:70]}) c = dig(s.sim.counts, n - 61);
				else if (n == 71) c = sky_cmd_pkg::CH_LO_C;
				else if (n inside {[73:79]}) c = dig(pms, n - 73);
				else if (n inside {[81:83]}) c = dig(pms, n - 74);
				else if (n == 84) c = sky_cmd_pkg::CH_LO_S;
				else if (n == 86) c = tneg ? sky_cmd_pkg::CH_MINUS : sky_cmd_pkg::CH_SPACE;
				else if (n inside {[87:89]}) c = dig({24'h0, tdeg}, n - 81);
				else if (n == 91) c = dig({24'h0, tdeg}, 9);
				else if (n == 92) c = sky_cmd_pkg::CH_UP_C;
				else if (n == 93) c = sky_cmd_pkg::CH_CR;
				else if (n == 94) c = sky_cmd_pkg::CH_LF;
			end
		end
		return c;
	endfunction

	// Handshakes and decoded conditions on the registered state.
	always_comb
	begin
		rx_ready_out = (st_r.line == sky_cmd_pkg::LN_NONE);
		rx_hs        = rx_valid_in && rx_ready_out;
		tx_hs        = st_r.tx_valid && tx_ready_in;
		is_digit     = (rx_data_in >= sky_cmd_pkg::CH_ZERO) && (rx_data_in <= sky_cmd_pkg::CH_NINE);
		exec_cmd     = rx_hs && (rx_data_in == sky_cmd_pkg::CH_X)
			&& (st_r.parse != sky_cmd_pkg::PS_IDLE);
		above        = !reading_neg_in && ({24'h0, reading_in} > st_r.ram_thresh);
		cur_len      = line_len(st_r.line);
	end

	// Next-state logic: interval timer, command parser, response sender.
	always_comb
	begin
		st_nxt = st_r;
		st_nxt.report_req = 1'b0;
		st_nxt.nv_wr.valid = 1'b0;

		// One-second tick; when the working period has elapsed, the report fires only if the live reading is above the working threshold.
		if (st_r.sec_cnt == 32'(CYCLES_PER_S - 1))
		begin
			st_nxt.sec_cnt = '0;
			if (st_r.ram_period != '0
				&& st_r.secs + 34'h1 >= sky_cmd_pkg::bcd2bin(st_r.ram_period))
			begin
				st_nxt.secs = '0;
				st_nxt.report_req = above;
			end
			else
				st_nxt.secs = st_r.secs + 34'h1;
		end
		else
			st_nxt.sec_cnt = st_r.sec_cnt + 32'h1;

		// Command parser: one byte per accepted handshake.
		if (rx_hs)
		begin
			case (st_r.parse)
				sky_cmd_pkg::PS_IDLE:
				begin
					// Only known command letters open a command; other bytes are dropped.
					st_nxt.acc = '0;
					st_nxt.cmd = rx_data_in;
					st_nxt.fld = 2'h0;
					if (rx_data_in inside {sky_cmd_pkg::CH_UP_P, sky_cmd_pkg::CH_LO_P,
						sky_cmd_pkg::CH_UP_T, sky_cmd_pkg::CH_LO_T,
						sky_cmd_pkg::CH_UP_I, sky_cmd_pkg::CH_LO_S})
						st_nxt.parse = sky_cmd_pkg::PS_NUM;
					else if (rx_data_in == sky_cmd_pkg::CH_UP_S)
						st_nxt.parse = sky_cmd_pkg::PS_SIM;
				end
				sky_cmd_pkg::PS_NUM:
				begin
					// Digits shift in; a decimal point or other filler is skipped.
					if (is_digit)
						st_nxt.acc = {st_r.acc[35:0], rx_data_in[3:0]};
					else if (rx_data_in == sky_cmd_pkg::CH_X)
					begin
						st_nxt.parse = sky_cmd_pkg::PS_IDLE;
						st_nxt.line = sky_cmd_pkg::LN_STAT;
						case (st_r.cmd)
							sky_cmd_pkg::CH_UP_P:
							begin
								st_nxt.nv_period  = st_r.acc;
								st_nxt.ram_period = st_r.acc;
								st_nxt.nv_wr = '{1'b1, 1'b0, st_r.acc};
								st_nxt.secs = '0;
							end
							sky_cmd_pkg::CH_LO_P:
							begin
								st_nxt.ram_period = st_r.acc;
								st_nxt.secs = '0;
							end
							sky_cmd_pkg::CH_UP_T:
							begin
								st_nxt.nv_thresh  = st_r.acc;
								st_nxt.ram_thresh = st_r.acc;
								st_nxt.nv_wr = '{1'b1, 1'b1, st_r.acc};
							end
							sky_cmd_pkg::CH_LO_T: st_nxt.ram_thresh = st_r.acc;
							sky_cmd_pkg::CH_LO_S: st_nxt.line = sky_cmd_pkg::LN_SREAD;
							default: st_nxt.line = sky_cmd_pkg::LN_STAT;
						endcase
					end
				end
				sky_cmd_pkg::PS_SIM:
				begin
					// Any byte but a digit closes the current field; x also ends the command.
					if (is_digit)
						st_nxt.acc = {st_r.acc[35:0], rx_data_in[3:0]};
					else
					begin
						case (st_r.fld)
							2'h1: st_nxt.sim.counts = st_r.acc;
							2'h2: st_nxt.sim.freq = st_r.acc;
							2'h3: st_nxt.sim.temp = st_r.acc;
							default: st_nxt.acc = '0;
						endcase
						st_nxt.acc = '0;
						if (rx_data_in == sky_cmd_pkg::CH_X)
						begin
							st_nxt.parse = sky_cmd_pkg::PS_IDLE;
							st_nxt.line = sky_cmd_pkg::LN_SSET;
						end
						else if (st_r.fld != 2'h3)
							st_nxt.fld = st_r.fld + 2'h1;
					end
				end
				default: st_nxt.parse = sky_cmd_pkg::PS_IDLE;
			endcase
		end

		// Response sender: load column 0 on start, step on each delivered byte.
		if (exec_cmd)
		begin
			st_nxt.idx = 7'h0;
			st_nxt.tx_valid = 1'b1;
			st_nxt.tx_data = line_char(st_nxt.line, 7'h0, st_r, period_ms, temp_neg,
				temp_deg, sim_mag_neg_in, sim_mag_in);
		end
		else if (tx_hs)
		begin
			if (st_r.idx == cur_len - 7'h1)
			begin
				st_nxt.tx_valid = 1'b0;
				st_nxt.line = sky_cmd_pkg::LN_NONE;
			end
			else
			begin
				st_nxt.idx = st_r.idx + 7'h1;
				st_nxt.tx_data = line_char(st_r.line, st_r.idx + 7'h1, st_r, period_ms,
					temp_neg, temp_deg, sim_mag_neg_in, sim_mag_in);
			end
		end
	end

	// State register with a synchronous reset.
	always_ff @(posedge clk_in)
	begin
		if (reset_in)
		begin
			st_r <= '0;
			st_r.parse <= sky_cmd_pkg::PS_IDLE;
			st_r.line <= sky_cmd_pkg::LN_NONE;
			st_r.nv_period <= sky_cmd_pkg::RST_PERIOD;
			st_r.ram_period <= sky_cmd_pkg::RST_PERIOD;
			st_r.nv_thresh <= sky_cmd_pkg::RST_THRESH;
			st_r.ram_thresh <= sky_cmd_pkg::RST_THRESH;
		end
		else
			st_r <= st_nxt;
	end

	// Outputs from the state register; serial_out and listener_port_out are constants.
	assign tx_valid_out      = st_r.tx_valid;
	assign tx_data_out       = st_r.tx_data;
	assign sim_out           = st_r.sim;
	assign nv_wr_out         = st_r.nv_wr;
	assign report_req_out    = st_r.report_req;
	assign serial_out        = SERIAL_BCD;
	assign connect_req_out   = st_r.tx_valid || st_r.report_req;
	assign listener_port_out = sky_cmd_pkg::LISTENER_PORT;

	AST_LF_LAST: assert property (@(posedge clk_in) disable iff (reset_in)
		tx_hs && st_r.idx == cur_len - 7'h1 |-> tx_data_out == sky_cmd_pkg::CH_LF)
		else $error("last byte of a line is not LF");
	AST_CR_BEFORE_LF: assert property (@(posedge clk_in) disable iff (reset_in)
		tx_hs && st_r.idx == cur_len - 7'h2 |-> tx_data_out == sky_cmd_pkg::CH_CR)
		else $error("byte before LF is not CR");
	AST_UPPER_P: assert property (@(posedge clk_in) disable iff (reset_in)
		exec_cmd && st_r.cmd == sky_cmd_pkg::CH_UP_P |=> st_r.nv_period == $past(st_r.acc)
		&& st_r.ram_period == $past(st_r.acc) && nv_wr_out.valid && !nv_wr_out.is_thresh)
		else $error("P did not store both period copies");
	AST_LOWER_P: assert property (@(posedge clk_in) disable iff (reset_in)
		exec_cmd && st_r.cmd == sky_cmd_pkg::CH_LO_P |=> $stable(st_r.nv_period)
		&& st_r.ram_period == $past(st_r.acc) && !nv_wr_out.valid)
		else $error("p touched the nonvolatile period");
	AST_UPPER_T: assert property (@(posedge clk_in) disable iff (reset_in)
		exec_cmd && st_r.cmd == sky_cmd_pkg::CH_UP_T |=> st_r.nv_thresh == $past(st_r.acc)
		&& st_r.ram_thresh == $past(st_r.acc) && nv_wr_out.valid && nv_wr_out.is_thresh)
		else $error("T did not store both threshold copies");
	AST_LOWER_T: assert property (@(posedge clk_in) disable iff (reset_in)
		exec_cmd && st_r.cmd == sky_cmd_pkg::CH_LO_T |=> $stable(st_r.nv_thresh)
		&& !nv_wr_out.valid)
		else $error("t touched the nonvolatile threshold");
	AST_STATUS_REPLY: assert property (@(posedge clk_in) disable iff (reset_in)
		exec_cmd && st_r.parse == sky_cmd_pkg::PS_NUM && st_r.cmd != sky_cmd_pkg::CH_LO_S
		|=> tx_valid_out && tx_data_out == sky_cmd_pkg::CH_UP_I && connect_req_out)
		else $error("setting or query gave no status line");
	AST_STATUS_SUFFIX: assert property (@(posedge clk_in) disable iff (reset_in)
		tx_hs && st_r.line == sky_cmd_pkg::LN_STAT && (st_r.idx == 7'h25 || st_r.idx == 7'h32)
		|-> tx_data_out == sky_cmd_pkg::CH_LO_M)
		else $error("threshold suffix missing");
	AST_SSET_MARK: assert property (@(posedge clk_in) disable iff (reset_in)
		tx_hs && st_r.line == sky_cmd_pkg::LN_SSET && st_r.idx == 7'h26
		|-> tx_data_out == sky_cmd_pkg::CH_LO_R)
		else $error("reading marker missing");
	AST_REPORT_DARK: assert property (@(posedge clk_in) disable iff (reset_in)
		report_req_out |-> !$past(reading_neg_in) && $past(st_r.ram_period) != '0)
		else $error("report for a bright reading");

endmodule

`default_nettype wire

//--- tb/host_sink.sv
`timescale 1ns/1ps
`default_nettype none

// Host end of the response link; it stalls at random, as a slow reader would.
module host_sink
#(
	parameter int IDLE_LIMIT = 40  // Quiet cycles before the host drops the link.
)
(
	input  wire logic clk_in,      // System clock.
	input  wire logic connect_in,  // The core asks for the connection.
	output logic      ready_out    // High when the host takes the offered byte.
);
	int quiet = IDLE_LIMIT;  // Cycles since the core last asked for the link.

	// Ready moves only just after an edge, so a byte may wait several cycles.
	initial ready_out = 1'b0;

	// The link opens on a request and drops after IDLE_LIMIT quiet cycles, which is
	// kept well below the report interval so a later report always gets through.
	always @(posedge clk_in)
	begin
		quiet <= connect_in ? 0 : ((quiet < IDLE_LIMIT) ? quiet + 1 : quiet);
		ready_out <= (connect_in || quiet < IDLE_LIMIT) && 1'($urandom % 2);
	end
endmodule

`default_nettype wire

//--- tb/sky_cmd_core_tb.sv
`timescale 1ns/1ps
`default_nettype none

// Sends commands to the core and checks each response byte in order.
module sky_cmd_core_tb;
	logic clk_in, reset_in, rx_valid, tx_ready, rdy, txv, rpt, con, rd_neg;
	logic [7:0]  rx_data, tx_data;
	logic [15:0] rd, port;
	logic [7:0]  exp_q[$];  // Response bytes still expected.
	int          err_count, checked, rpt_n, nv_n, rv;
	logic [31:0] serial;    // Serial number shown by the core.
	sky_cmd_pkg::nv_write_s nvw;
	sky_cmd_pkg::sim_vals_s sim;  // Stored simulation values shown by the core.

	sky_cmd_core #(.CYCLES_PER_S(20), .SERIAL_BCD(32'h24681357)) dut_u (.clk_in(clk_in),
		.reset_in(reset_in),
		.rx_valid_in(rx_valid), .rx_data_in(rx_data), .rx_ready_out(rdy),
		.tx_valid_out(txv), .tx_data_out(tx_data), .tx_ready_in(tx_ready),
		.sim_mag_neg_in(1'b0), .sim_mag_in(16'h1804), .reading_neg_in(rd_neg),
		.reading_in(rd), .sim_out(sim), .nv_wr_out(nvw), .report_req_out(rpt),
		.serial_out(serial), .connect_req_out(con), .listener_port_out(port));
	host_sink host_u (.clk_in(clk_in), .connect_in(con), .ready_out(tx_ready));

	// Compares one named value and counts the outcome.
	task automatic chk_val(input string n, input logic [31:0] e, input logic [31:0] s);
		checked++;
		if (s !== e)
		begin
			$display("wrong value %s expected %h seen %h", n, e, s);
			err_count++;
		end
	endtask

	// Prints the verdict and stops the run.
	task automatic finish_test();
		if (err_count == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// Notes the expected line, then offers each byte until it is taken.
	task automatic send(input string c, input string r);
		foreach (r[i]) exp_q.push_back(r[i]);
		exp_q.push_back(8'h0D);
		exp_q.push_back(8'h0A);
		foreach (c[i])
		begin
			rx_valid <= 1'b1;
			rx_data <= c[i];
			do @(posedge clk_in); while (rdy !== 1'b1);
		end
		rx_valid <= 1'b0;
		@(posedge clk_in);
	endtask

	// Clock of 5 ns.
	initial
	begin
		clk_in = 1'b0;
		forever #2.5 clk_in = ~clk_in;
	end

	// Takes the oldest noted byte whenever the core hands one over.
	always @(posedge clk_in)
	begin
		if (rpt === 1'b1) rpt_n++;
		if (nvw.valid === 1'b1) nv_n++;
		if (txv === 1'b1 && tx_ready === 1'b1)
		begin
			chk_val("tx_data", exp_q.size() ? exp_q.pop_front() : 8'hFF, tx_data);
			chk_val("connect", 1, con);
		end
	end

	// Cuts a hang short.
	initial
	begin
		repeat (20000) @(posedge clk_in);
		err_count++;
		finish_test();
	end

	// Main sequence: settings, status lines, simulation read, interval reports.
	initial
	begin
		reset_in = 1'b1; rx_valid = 1'b0; rx_data = 8'h00; rd = 16'h1700; rd_neg = 1'b0;
		err_count = 0; checked = 0; rpt_n = 0; nv_n = 0;
		void'($urandom(32'hA28A));
		repeat (20) @(posedge clk_in);
		reset_in <= 1'b0;
		@(posedge clk_in);
		chk_val("port", 16'h2712, port);
		send("zIx", "I,0000000000s,0000000000s,00000000.00m,00000000.00m");
		// Simulation runs while no period is set, so no interval report cuts in.
		send("S;0000000000/0000000000-0000000000x",
			{"S,0000000000c,0000000000f,0000000000t,r, 18.04m,",
			"0000000000Hz,0000000000c,0000000.000s,-050.0C"});
		send("S,0000460800,0000000360,0000000256x",
			{"S,0000460800c,0000000360f,0000000256t,r, 18.04m,",
			"0000000360Hz,0000460800c,0000001.000s, 032.5C"});
		send("sx", "s,0000460800c,0000000360f,0000000256t");
		send("P0000000360x", "I,0000000360s,0000000360s,00000000.00m,00000000.00m");
		rv = $urandom % 1000000000;
		send($sformatf("p%010dx", rv),
			$sformatf("I,0000000360s,%010ds,00000000.00m,00000000.00m", rv));
		send("p0000000005x", "I,0000000360s,0000000005s,00000000.00m,00000000.00m");
		send("T00000017.60x", "I,0000000360s,0000000005s,00000017.60m,00000017.60m");
		send("t00000016.00x", "I,0000000360s,0000000005s,00000017.60m,00000016.00m");
		wait (exp_q.size() == 0);
		chk_val("nv_writes", 2, nv_n);
		chk_val("sim_counts", 32'h00460800, sim.counts[31:0]);
		chk_val("sim_temp", 32'h00000256, sim.temp[31:0]);
		chk_val("serial", 32'h24681357, serial);
		rpt_n = 0;
		repeat (230) @(posedge clk_in);
		chk_val("reports", 1, rpt_n >= 2);
		rd <= 16'h1600;
		repeat (2) @(posedge clk_in);
		rpt_n = 0;
		repeat (230) @(posedge clk_in);
		chk_val("reports_at_limit", 0, rpt_n);
		rd <= 16'h1700;
		rd_neg <= 1'b1;
		repeat (2) @(posedge clk_in);
		rpt_n = 0;
		repeat (230) @(posedge clk_in);
		chk_val("reports_negative", 0, rpt_n);
		finish_test();
	end
endmodule

`default_nettype wire
